/* include/otntx_pkg.sv */
// constants, types and register map of the transmit mode and clock select block
package otntx_pkg;
  localparam int unsigned DW = 32;
  localparam int unsigned AW = 8;
  // register byte addresses
  localparam logic [AW-1:0] ADDR_CTRL     = 8'h00;
  localparam logic [AW-1:0] ADDR_RATE     = 8'h04;
  localparam logic [AW-1:0] ADDR_PAYLOAD  = 8'h08;
  localparam logic [AW-1:0] ADDR_PORT2    = 8'h0C;
  localparam logic [AW-1:0] ADDR_TRACE    = 8'h10;
  localparam logic [AW-1:0] ADDR_USER_IDX = 8'h14;
  localparam logic [AW-1:0] ADDR_USER_DAT = 8'h18;
  localparam logic [AW-1:0] ADDR_OH       = 8'h1C;
  localparam logic [AW-1:0] ADDR_STATUS   = 8'h20;
  // control field positions
  localparam int unsigned C_MODE = 0;
  localparam int unsigned C_FEC = 2;
  localparam int unsigned C_TTI_FREE = 3;
  localparam int unsigned C_REF_P1 = 4;
  localparam int unsigned C_REF_P2 = 5;
  localparam int unsigned C_DIV64 = 6;
  localparam int unsigned C_SYNC = 7;
  localparam int unsigned C_SRC = 9;
  localparam int unsigned C_TWO_PORTS = 11;
  localparam int unsigned C_FOLLOW = 12;
  localparam int unsigned C_MUX = 13;
  localparam int unsigned C_SPARE = 14;
  localparam int unsigned CTRL_BITS = 15;
  localparam logic [DW-1:0] CTRL_RST = 32'h0000_0000;
  localparam logic [DW-1:0] OH_RST = 32'hF6F6_F628;
  // frame shape in words
  localparam int unsigned FRAME_WORDS = 64;
  localparam int unsigned OH_WORDS = 4;
  localparam int unsigned FEC_WORDS = 8;
  localparam int unsigned TTI_BYTES = 64;
  localparam int unsigned USER_WORDS = 64;
  // reference and sync divider half periods minus one, in transmit ticks
  localparam logic [4:0] HALF_DIV16 = 5'h07;
  localparam logic [4:0] HALF_DIV64 = 5'h1F;
  localparam logic [3:0] HALF_SYNC8 = 4'h3;
  localparam logic [3:0] HALF_SYNC16 = 4'h7;
  localparam logic [1:0] DEFAULT_LANES = 2'h0;

  typedef enum logic [1:0] {MODE_OFF, MODE_NORMAL, MODE_THROUGH, MODE_OH_REPLACE} otntx_mode_t;
  typedef enum logic [1:0] {SRC_INTERNAL, SRC_EXTERNAL, SRC_GPS, SRC_RECEIVED} otntx_src_t;
  typedef enum logic [1:0] {SYNC_OFF, SYNC_DIV8, SYNC_DIV16, SYNC_RSVD} otntx_sync_t;
  typedef enum logic [3:0] {
    RATE_OTU1, RATE_OTU2, RATE_OTU2_EXT, RATE_OTU1E, RATE_OTU2E, RATE_OTU1F,
    RATE_OTU2F, RATE_OTU3, RATE_OTU3E1, RATE_OTU3E2, RATE_OTU4
  } otntx_rate_t;
  typedef enum logic [3:0] {
    CL_PRBS, CL_NULL, CL_GBE, CL_10GBE, CL_40GBE, CL_100GBE, CL_ETH_VAR,
    CL_MPLS, CL_IPV4, CL_IPV6, CL_SDH, CL_TRANSPARENT_RANDOM_PAYLOAD, CL_TRANS_NULL
  } otntx_client_t;
  typedef enum logic [1:0] {PAT_PRBS, PAT_USER32, PAT_USER2048, PAT_RSVD} otntx_pat_t;
  // prbs order selector codes
  localparam logic [2:0] PRBS9 = 3'h0;
  localparam logic [2:0] PRBS11 = 3'h1;
  localparam logic [2:0] PRBS15 = 3'h2;
  localparam logic [2:0] PRBS20 = 3'h3;
  localparam logic [2:0] PRBS23 = 3'h4;
  localparam logic [2:0] PRBS31 = 3'h5;
  localparam logic [30:0] PRBS_SEED = 31'h7FFF_FFFF;
endpackage

/* rtl/otntx_top.sv */
// transmit mode, clock select and frame generation for one optical transport port
`timescale 1ns/1ns
module otntx_top (
  input  wire logic                        REF_CLK_I,
  input  wire logic                        SRST_I,
  input  wire logic [otntx_pkg::AW-1:0]    REG_ADDR_I,
  input  wire logic [otntx_pkg::DW-1:0]    REG_WDATA_I,
  input  wire logic                        REG_WR_I,
  input  wire logic                        REG_RD_I,
  output logic      [otntx_pkg::DW-1:0]    REG_RDATA_O,
  input  wire logic                        INT_TICK_I,
  input  wire logic                        EXT_TICK_I,
  input  wire logic                        GPS_TICK_I,
  input  wire logic                        RX_TICK_I,
  input  wire logic                        EXT_CLK_PRESENT_I,
  input  wire logic                        GPS_CLK_PRESENT_I,
  input  wire logic                        RX_CLK_PRESENT_I,
  input  wire logic [otntx_pkg::DW-1:0]    RX_DATA_I,
  input  wire logic                        RX_VALID_I,
  input  wire logic                        RX_SOF_I,
  input  wire logic                        RX_OH_I,
  output logic      [otntx_pkg::DW-1:0]    TX_DATA_O,
  output logic                             TX_VALID_O,
  output logic                             TX_SOF_O,
  output logic                             TX_OH_O,
  output logic                             REF_CLK_P1_O,
  output logic                             REF_CLK_P2_O,
  output logic                             SYNC_CLK_O,
  output logic      [7:0]                  LANE_MAP_O,
  output otntx_pkg::otntx_rate_t           RATE_O,
  output otntx_pkg::otntx_client_t         CLIENT_O
);
  import otntx_pkg::*;

  // register file
  logic [CTRL_BITS-1:0] ctrl_q, port2_q;
  logic [15:0]          rate_q;
  logic [5:0]           pay_q;
  logic [DW-1:0]        oh_q;
  logic [7:0]           tti_mem [TTI_BYTES];
  logic [DW-1:0]        user_mem [USER_WORDS];
  logic [5:0]           user_idx_q;
  logic [DW-1:0]        rdata_q;

  wire wr_ctrl  = REG_WR_I && (REG_ADDR_I == ADDR_CTRL);
  wire wr_rate  = REG_WR_I && (REG_ADDR_I == ADDR_RATE);
  wire wr_pay   = REG_WR_I && (REG_ADDR_I == ADDR_PAYLOAD);
  wire wr_port2 = REG_WR_I && (REG_ADDR_I == ADDR_PORT2);
  wire wr_trace = REG_WR_I && (REG_ADDR_I == ADDR_TRACE);
  wire wr_uidx  = REG_WR_I && (REG_ADDR_I == ADDR_USER_IDX);
  wire wr_udat  = REG_WR_I && (REG_ADDR_I == ADDR_USER_DAT);
  wire wr_oh    = REG_WR_I && (REG_ADDR_I == ADDR_OH);

  // port 1 wins when both enables are asked for, so both never drive together
  wire [CTRL_BITS-1:0] wctrl = REG_WDATA_I[CTRL_BITS-1:0];
  wire ref_p1_new = wctrl[C_REF_P1];
  wire ref_p2_new = wctrl[C_REF_P2] && !wctrl[C_REF_P1];
  wire [CTRL_BITS-1:0] ctrl_d = {wctrl[CTRL_BITS-1:C_REF_P2+1], ref_p2_new, ref_p1_new,
                                 wctrl[C_REF_P1-1:0]};

  always_ff @(posedge REF_CLK_I) begin
    if (SRST_I) begin
      ctrl_q     <= CTRL_RST[CTRL_BITS-1:0];
      port2_q    <= CTRL_RST[CTRL_BITS-1:0];
      rate_q     <= '0;
      pay_q      <= '0;
      oh_q       <= OH_RST;
      user_idx_q <= '0;
    end else begin
      if (wr_ctrl) begin
        ctrl_q <= ctrl_d;
      end
      if (wr_port2) begin
        port2_q <= REG_WDATA_I[CTRL_BITS-1:0];
      end
      if (wr_rate) begin
        rate_q <= REG_WDATA_I[15:0];
      end
      if (wr_pay) begin
        pay_q <= REG_WDATA_I[5:0];
      end
      if (wr_oh) begin
        oh_q <= REG_WDATA_I;
      end
      if (wr_uidx) begin
        user_idx_q <= REG_WDATA_I[5:0];
      end else if (wr_udat) begin
        user_idx_q <= user_idx_q + 6'h01;
      end
    end
  end

  // storage arrays carry no reset; software loads them before use
  always_ff @(posedge REF_CLK_I) begin
    if (wr_trace) begin
      tti_mem[REG_WDATA_I[13:8]] <= REG_WDATA_I[7:0];
    end
    if (wr_udat) begin
      user_mem[user_idx_q] <= REG_WDATA_I;
    end
  end

  // decoded settings
  wire otntx_mode_t sel_mode = otntx_mode_t'(ctrl_q[C_MODE +: 2]);
  wire              thru_sel = (sel_mode == MODE_THROUGH) || (sel_mode == MODE_OH_REPLACE);
  wire otntx_src_t  sel_src  = thru_sel ? SRC_RECEIVED : otntx_src_t'(ctrl_q[C_SRC +: 2]);
  wire otntx_rate_t rate     = otntx_rate_t'(rate_q[3:0]);
  wire [3:0]        cl_raw   = rate_q[7:4];
  wire              cl_block = ctrl_q[C_TWO_PORTS] &&
                               (cl_raw == CL_ETH_VAR || cl_raw == CL_MPLS ||
                                cl_raw == CL_IPV4 || cl_raw == CL_IPV6);
  wire otntx_client_t client = cl_block ? CL_PRBS : otntx_client_t'(cl_raw);
  wire              multi_lane = (rate == RATE_OTU3) || (rate == RATE_OTU3E1) ||
                                 (rate == RATE_OTU3E2) || (rate == RATE_OTU4);
  // port 2 effective settings, copied live from port 1 when following
  wire [CTRL_BITS-1:0] port2_eff = port2_q[C_FOLLOW] ? ctrl_q : port2_q;

  // the source, mode and ratios switch at frame start, or at once while the mode is off, so nothing is cut short
  otntx_src_t  src_q;
  otntx_mode_t mode_q;
  logic        div64_q;
  logic [1:0]  sync_q;
  logic [5:0]  wcnt_q;
  logic [5:0]  mfas_q;

  // transmit tick from the selected source
  logic tx_tick;
  always_comb begin
    unique case (src_q)
      SRC_INTERNAL: tx_tick = INT_TICK_I;
      SRC_EXTERNAL: tx_tick = EXT_TICK_I;
      SRC_GPS:      tx_tick = GPS_TICK_I;
      SRC_RECEIVED: tx_tick = RX_TICK_I;
    endcase
  end
  wire         frame_end = (wcnt_q == 6'(FRAME_WORDS - 1));
  wire         idle_sw   = (mode_q == MODE_OFF) || (tx_tick && frame_end);

  always_ff @(posedge REF_CLK_I) begin
    if (SRST_I) begin
      src_q   <= SRC_INTERNAL;
      mode_q  <= MODE_OFF;
      div64_q <= 1'b0;
      sync_q  <= SYNC_OFF;
    end else if (idle_sw) begin
      src_q   <= sel_src;
      mode_q  <= sel_mode;
      div64_q <= ctrl_q[C_DIV64];
      sync_q  <= ctrl_q[C_SYNC +: 2];
    end
  end

  // frame word counter, multiframe counter drives the trace byte index
  always_ff @(posedge REF_CLK_I) begin
    if (SRST_I || mode_q == MODE_OFF) begin
      wcnt_q <= '0;
      mfas_q <= '0;
    end else if (tx_tick) begin
      wcnt_q <= frame_end ? 6'h00 : wcnt_q + 6'h01;
      if (frame_end) mfas_q <= mfas_q + 6'h01;
    end
  end

  // prbs generator, 32 bits per tick
  function automatic logic [62:0] prbs_step(input logic [30:0] s, input logic [2:0] ord);
    logic [30:0] st;
    logic [31:0] out;
    logic        fb;
    st  = s;
    out = '0;
    for (int i = 0; i < DW; i++) begin
      unique case (ord)
        PRBS9:   fb = st[8] ^ st[4];
        PRBS11:  fb = st[10] ^ st[8];
        PRBS15:  fb = st[14] ^ st[13];
        PRBS20:  fb = st[19] ^ st[2];
        PRBS23:  fb = st[22] ^ st[17];
        default: fb = st[30] ^ st[27];
      endcase
      out = {out[30:0], fb};
      st  = {st[29:0], fb};
    end
    return {st, out};
  endfunction

  logic [30:0] prbs_q, dummy_q;
  wire  [62:0] prbs_nx  = prbs_step(prbs_q, pay_q[2:0]);
  wire  [62:0] dummy_nx = prbs_step(dummy_q, PRBS31);
  wire         pay_word = (wcnt_q >= 6'(OH_WORDS));
  wire         fec_word = ctrl_q[C_FEC] && (wcnt_q >= 6'(FRAME_WORDS - FEC_WORDS));
  wire         gen_adv  = tx_tick && pay_word && !fec_word;

  always_ff @(posedge REF_CLK_I) begin
    if (SRST_I) begin
      prbs_q  <= PRBS_SEED;
      dummy_q <= PRBS_SEED;
    end else if (gen_adv) begin
      prbs_q  <= prbs_nx[62:32];
      dummy_q <= dummy_nx[62:32];
    end
  end

  // user pattern walks 64 words, or holds word 0 for the short pattern
  logic [5:0] upos_q;
  wire otntx_pat_t pat = otntx_pat_t'(pay_q[5:4]);
  always_ff @(posedge REF_CLK_I) begin
    if (SRST_I) begin
      upos_q <= '0;
    end else if (gen_adv && pat == PAT_USER2048) begin
      upos_q <= upos_q + 6'h01;
    end
  end

  // payload selection
  wire [DW-1:0] prbs_word = pay_q[3] ? ~prbs_nx[31:0] : prbs_nx[31:0];
  wire [DW-1:0] user_word = (pat == PAT_USER2048) ? user_mem[upos_q] : user_mem[0];
  wire          null_cl   = (client == CL_NULL) || (client == CL_TRANS_NULL);
  wire [DW-1:0] main_word = null_cl ? '0 : (pat == PAT_PRBS) ? prbs_word : user_word;
  // spare tributaries sit in odd payload words when multiplexing
  wire          spare_pos = ctrl_q[C_MUX] && wcnt_q[0];
  wire [DW-1:0] spare_wrd = ctrl_q[C_SPARE] ? dummy_nx[31:0] : main_word;
  wire [DW-1:0] load_word = spare_pos ? spare_wrd : main_word;

  // trace byte: structured format pins the start markers of each half to zero
  wire [5:0] tti_idx   = mfas_q;
  wire       tti_fixed = !ctrl_q[C_TTI_FREE] && (tti_idx[4:0] == 5'h00);
  wire [7:0] tti_byte  = tti_fixed ? 8'h00 : tti_mem[tti_idx];
  wire [DW-1:0] gen_oh = (wcnt_q == 6'h00) ? oh_q : {oh_q[31:8], tti_byte};

  // parity area: running xor of the frame stands in for the code word check bytes
  logic [DW-1:0] par_q;
  always_ff @(posedge REF_CLK_I) begin
    if (SRST_I || (tx_tick && frame_end)) begin
      par_q <= '0;
    end else if (tx_tick && !fec_word) begin
      par_q <= par_q ^ (pay_word ? load_word : gen_oh);
    end
  end

  // output word per mode
  logic [DW-1:0] tx_d;
  logic          tx_v, tx_s, tx_o;
  always_comb begin
    tx_d = '0;
    tx_v = 1'b0;
    tx_s = 1'b0;
    tx_o = 1'b0;
    unique case (mode_q)
      MODE_OFF: begin
        tx_v = 1'b0;
      end
      MODE_NORMAL: begin
        tx_v = tx_tick;
        // markers only stand beside a real word, never between ticks
        tx_s = tx_tick && (wcnt_q == 6'h00);
        tx_o = tx_tick && !pay_word;
        tx_d = fec_word ? par_q : pay_word ? load_word : gen_oh;
      end
      MODE_THROUGH: begin
        tx_v = RX_VALID_I;
        tx_s = RX_SOF_I;
        tx_o = RX_OH_I;
        tx_d = RX_DATA_I;
      end
      MODE_OH_REPLACE: begin
        tx_v = RX_VALID_I;
        tx_s = RX_SOF_I;
        tx_o = RX_OH_I;
        tx_d = RX_OH_I ? (RX_SOF_I ? oh_q : {oh_q[31:8], tti_byte}) : RX_DATA_I;
      end
    endcase
  end

  always_ff @(posedge REF_CLK_I) begin
    if (SRST_I) begin
      TX_DATA_O  <= '0;
      TX_VALID_O <= 1'b0;
      TX_SOF_O   <= 1'b0;
      TX_OH_O    <= 1'b0;
    end else begin
      TX_DATA_O  <= tx_d;
      TX_VALID_O <= tx_v;
      TX_SOF_O   <= tx_s;
      TX_OH_O    <= tx_o;
    end
  end

  // reference divider: toggles on the transmit tick; ratio changes at frame start, or at once while the mode is off
  logic [4:0] rdiv_q;
  logic       rclk_q;
  wire  [4:0] rhalf = div64_q ? HALF_DIV64 : HALF_DIV16;
  always_ff @(posedge REF_CLK_I) begin
    if (SRST_I) begin
      rdiv_q <= '0;
      rclk_q <= 1'b0;
    end else if (tx_tick) begin
      if (rdiv_q >= rhalf) begin
        rdiv_q <= '0;
        rclk_q <= !rclk_q;
      end else begin
        rdiv_q <= rdiv_q + 5'h01;
      end
    end
  end
  wire ref_kill = (rate == RATE_OTU1) && div64_q;

  // sync divider from the data clock
  logic [3:0] sdiv_q;
  logic       sclk_q;
  wire  [3:0] shalf = (sync_q == SYNC_DIV16) ? HALF_SYNC16 : HALF_SYNC8;
  always_ff @(posedge REF_CLK_I) begin
    if (SRST_I || sync_q == SYNC_OFF || sync_q == SYNC_RSVD) begin
      sdiv_q <= '0;
      sclk_q <= 1'b0;
    end else if (tx_tick) begin
      if (sdiv_q >= shalf) begin
        sdiv_q <= '0;
        sclk_q <= !sclk_q;
      end else begin
        sdiv_q <= sdiv_q + 4'h1;
      end
    end
  end

  always_ff @(posedge REF_CLK_I) begin
    if (SRST_I) begin
      REF_CLK_P1_O <= 1'b0;
      REF_CLK_P2_O <= 1'b0;
      SYNC_CLK_O   <= 1'b0;
    end else begin
      REF_CLK_P1_O <= rclk_q && ctrl_q[C_REF_P1] && !ref_kill;
      REF_CLK_P2_O <= rclk_q && ctrl_q[C_REF_P2] && !ref_kill;
      SYNC_CLK_O   <= sclk_q;
    end
  end

  // lane map only meaningful on the multi-lane levels
  always_ff @(posedge REF_CLK_I) begin
    if (SRST_I) begin
      LANE_MAP_O <= '0;
      RATE_O     <= RATE_OTU1;
      CLIENT_O   <= CL_PRBS;
    end else begin
      LANE_MAP_O <= multi_lane ? rate_q[15:8] : {4{DEFAULT_LANES}};
      RATE_O     <= rate;
      CLIENT_O   <= client;
    end
  end

  // read port, data in the cycle after the strobe
  wire [2:0] present = {RX_CLK_PRESENT_I, GPS_CLK_PRESENT_I, EXT_CLK_PRESENT_I};
  logic [DW-1:0] rd_mux;
  always_comb begin
    unique case (REG_ADDR_I)
      ADDR_CTRL:     rd_mux = DW'(ctrl_q);
      ADDR_RATE:     rd_mux = {16'h0000, rate_q[15:8], client, rate};
      ADDR_PAYLOAD:  rd_mux = DW'(pay_q);
      ADDR_PORT2:    rd_mux = DW'(port2_eff);
      ADDR_USER_IDX: rd_mux = DW'(user_idx_q);
      ADDR_OH:       rd_mux = oh_q;
      ADDR_STATUS:   rd_mux = {16'h0000, mfas_q, src_q, mode_q, 1'b0, present, 2'b00};
      default:       rd_mux = '0;
    endcase
  end

  always_ff @(posedge REF_CLK_I) begin
    if (SRST_I) begin
      rdata_q <= '0;
    end else if (REG_RD_I) begin
      rdata_q <= rd_mux;
    end else begin
      rdata_q <= '0;
    end
  end
  assign REG_RDATA_O = rdata_q;

endmodule // otntx_top

/* test/otntx_top_properties.sv */
// port assertions for the transmit mode and clock select block
`timescale 1ns/1ns
module otntx_checker (
  input wire logic                     REF_CLK_I,
  input wire logic                     SRST_I,
  input wire logic                     REG_WR_I,
  input wire logic                     REG_RD_I,
  input wire logic [otntx_pkg::DW-1:0] REG_RDATA_O,
  input wire logic                     INT_TICK_I,
  input wire logic                     EXT_TICK_I,
  input wire logic                     GPS_TICK_I,
  input wire logic                     RX_TICK_I,
  input wire logic                     RX_VALID_I,
  input wire logic                     TX_VALID_O,
  input wire logic                     TX_SOF_O,
  input wire logic                     TX_OH_O,
  input wire logic                     REF_CLK_P1_O,
  input wire logic                     REF_CLK_P2_O,
  input wire logic                     SYNC_CLK_O,
  input wire logic [7:0]               LANE_MAP_O,
  input otntx_pkg::otntx_rate_t        RATE_O
);
  import otntx_pkg::*;
  default clocking @(posedge REF_CLK_I); endclocking
  default disable iff (SRST_I);
  logic [6:0] wcnt_q;
  logic       seen_q;
  wire        cause = INT_TICK_I | EXT_TICK_I | GPS_TICK_I | RX_TICK_I | RX_VALID_I;
  // words since the last frame start; seen_q masks the partial first frame
  always_ff @(posedge REF_CLK_I) begin
    if (SRST_I) begin
      wcnt_q <= 7'h00;
      seen_q <= 1'b0;
    end else if (TX_VALID_O) begin
      wcnt_q <= TX_SOF_O ? 7'h01 : wcnt_q + 7'h01;
      seen_q <= seen_q | TX_SOF_O;
    end
  end
  a_valid_has_cause: assert property (TX_VALID_O |-> $past(cause)) else $error("word without tick");
  a_sof_is_oh: assert property (TX_SOF_O |-> TX_OH_O && TX_VALID_O) else $error("frame start not oh");
  a_oh_four_words: assert property (TX_VALID_O && !TX_SOF_O && seen_q |-> TX_OH_O == (wcnt_q < 7'h04))
    else $error("oh flag misplaced");
  a_frame_whole_len: assert property (TX_SOF_O && seen_q |-> wcnt_q == 7'h40) else $error("frame cut");
  a_rdata_idle_zero: assert property (!$past(REG_RD_I) |-> REG_RDATA_O == 32'h0) else $error("stale rdata");
  a_ref_one_port: assert property (!(REF_CLK_P1_O && REF_CLK_P2_O)) else $error("two ref outputs");
  a_ref_on_tick: assert property ($changed(REF_CLK_P1_O) |-> $past(cause | REG_WR_I, 2) || $past(REG_WR_I, 3))
    else $error("ref moved without tick");
  a_sync_on_tick: assert property ($changed(SYNC_CLK_O) |-> $past(cause | REG_WR_I, 2) ||
    $past(cause | REG_WR_I, 3) || $past(REG_WR_I, 4))
    else $error("sync moved without tick");
  a_lane_low_zero: assert property (RATE_O < RATE_OTU3 && $stable(RATE_O) |-> LANE_MAP_O == 8'h00)
    else $error("lane map on low rate");
  c_frame: cover property (TX_SOF_O && seen_q);
  c_ref: cover property ($rose(REF_CLK_P1_O));
  c_sync: cover property ($rose(SYNC_CLK_O));
  c_read: cover property (REG_RD_I);
endmodule // otntx_checker
bind otntx_top otntx_checker u_chk (.REF_CLK_I(REF_CLK_I), .SRST_I(SRST_I), .REG_WR_I(REG_WR_I),
  .REG_RD_I(REG_RD_I), .REG_RDATA_O(REG_RDATA_O), .INT_TICK_I(INT_TICK_I), .EXT_TICK_I(EXT_TICK_I),
  .GPS_TICK_I(GPS_TICK_I), .RX_TICK_I(RX_TICK_I), .RX_VALID_I(RX_VALID_I), .TX_VALID_O(TX_VALID_O),
  .TX_SOF_O(TX_SOF_O), .TX_OH_O(TX_OH_O), .REF_CLK_P1_O(REF_CLK_P1_O), .REF_CLK_P2_O(REF_CLK_P2_O),
  .SYNC_CLK_O(SYNC_CLK_O), .LANE_MAP_O(LANE_MAP_O), .RATE_O(RATE_O));

/* test/otntx_far_end.sv */
// far-end model: supplies the received 64-word frame stream and its timing
`timescale 1ns/1ns
module otntx_far_end (
  input  wire logic                     clk_i,
  input  wire logic                     srst_i,
  input  wire logic                     send_i,
  output logic [otntx_pkg::DW-1:0]      rx_data_o,
  output logic                          rx_valid_o,
  output logic                          rx_sof_o,
  output logic                          rx_oh_o
);
  import otntx_pkg::*;
  logic [5:0] idx_q;
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      idx_q      <= 6'h00;
      rx_valid_o <= 1'b0;
      rx_sof_o   <= 1'b0;
      rx_oh_o    <= 1'b0;
      rx_data_o  <= 32'h0;
    end else begin
      idx_q      <= send_i ? idx_q + 6'h01 : 6'h00;
      rx_valid_o <= send_i;
      rx_sof_o   <= send_i && idx_q == 6'h00;
      rx_oh_o    <= send_i && idx_q < 6'h04;
      // idle line inverts so a stale word never looks like data
      rx_data_o  <= send_i ? {8'hA5, 18'h0, idx_q} : ~rx_data_o;
    end
  end
endmodule // otntx_far_end

/* test/otn_transmit_mode_and_clock_select_bench.sv */
// self-checking bench for the transmit mode and clock select block
`timescale 1ns/1ns
module otn_transmit_mode_and_clock_select_bench;
  import otntx_pkg::*;
  logic clk = 1'b0, srst = 1'b1, wr = 1'b0, rd = 1'b0, tick = 1'b0, tick_en = 1'b0, send = 1'b0;
  logic ext_p = 1'b1, gps_p = 1'b0, rx_p = 1'b1;
  logic [7:0]  addr = 8'h00;
  logic [31:0] wdata = 32'h0, pex;
  logic        poh, psof;
  wire  [31:0] rdata, tx_data, rx_data;
  wire         tx_valid, tx_sof, tx_oh, ref1, ref2, sync, rx_valid, rx_sof, rx_oh;
  wire  [7:0]  lanes;
  otntx_rate_t   rate;
  otntx_client_t client;
  int mismatches = 0, n_checks = 0;
  always #4 clk = ~clk;
  always @(posedge clk) begin
    tick <= tick_en & ~tick;
    pex  <= rx_data;
    poh  <= rx_oh;
    psof <= rx_sof;
  end
  otntx_top dut (.REF_CLK_I(clk), .SRST_I(srst), .REG_ADDR_I(addr), .REG_WDATA_I(wdata), .REG_WR_I(wr),
    .REG_RD_I(rd), .REG_RDATA_O(rdata), .INT_TICK_I(tick), .EXT_TICK_I(1'b0), .GPS_TICK_I(1'b0),
    .RX_TICK_I(rx_valid), .EXT_CLK_PRESENT_I(ext_p), .GPS_CLK_PRESENT_I(gps_p), .RX_CLK_PRESENT_I(rx_p),
    .RX_DATA_I(rx_data), .RX_VALID_I(rx_valid), .RX_SOF_I(rx_sof), .RX_OH_I(rx_oh), .TX_DATA_O(tx_data),
    .TX_VALID_O(tx_valid), .TX_SOF_O(tx_sof), .TX_OH_O(tx_oh), .REF_CLK_P1_O(ref1), .REF_CLK_P2_O(ref2),
    .SYNC_CLK_O(sync), .LANE_MAP_O(lanes), .RATE_O(rate), .CLIENT_O(client));
  otntx_far_end far (.clk_i(clk), .srst_i(srst), .send_i(send), .rx_data_o(rx_data), .rx_valid_o(rx_valid),
    .rx_sof_o(rx_sof), .rx_oh_o(rx_oh));
  task automatic test_done;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    n_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic bound(input int n, input int lim, input string what);
    if (n >= lim) begin
      chk(n, 0, what);
      test_done();
    end
  endtask
  task automatic wrr(input logic [7:0] a, input logic [31:0] d);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] m, input string what);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    chk(rdata & m, exp, what);
    @(posedge clk);
  endtask
  // cycles between two changes of the reference or the sync output
  task automatic gap(input bit s, input int exp, input string what);
    int n;
    logic v;
    for (int i = 0; i < 3; i++) begin
      n = 0;
      v = s ? sync : ref1;
      do begin
        @(negedge clk);
        n++;
      end while ((s ? sync : ref1) === v && n < 300);
      bound(n, 300, what);
    end
    chk(n, exp, what);
    @(posedge clk);
  endtask
  task automatic t_reset;
    rdc(ADDR_CTRL, CTRL_RST, 32'hFFFF_FFFF, "ctrl reset");
    rdc(ADDR_OH, OH_RST, 32'hFFFF_FFFF, "oh reset");
    rdc(ADDR_PORT2, 32'h0, 32'hFFFF_FFFF, "port2 reset");
    wrr(ADDR_STATUS, 32'hFFFF_FFFF);
    rdc(ADDR_STATUS, 32'h14, 32'h3DC, "status");
    rdc(8'h24, 32'h0, 32'hFFFF_FFFF, "unmapped");
    $display("test reset done");
  endtask
  task automatic t_regs;
    logic [3:0] c;
    for (int r = 0; r < 11; r++) begin
      wrr(ADDR_RATE, {16'h0, 8'hE4, 4'h0, r[3:0]});
      @(negedge clk);
      chk(rate, r[3:0], "rate");
      chk(lanes, r >= 7 ? 8'hE4 : 8'h00, "lane map");
      @(posedge clk);
    end
    wrr(ADDR_CTRL, 32'h800);
    for (int i = 2; i < 10; i++) begin
      c = i[3:0];
      wrr(ADDR_RATE, {24'h0, c, 4'h1});
      @(negedge clk);
      chk(client, (c >= 4'h6) ? 4'h0 : c, "client");
      @(posedge clk);
    end
    wrr(ADDR_CTRL, 32'h20);
    wrr(ADDR_CTRL, 32'h10);
    wrr(ADDR_CTRL, 32'h30);
    rdc(ADDR_CTRL, 32'h10, 32'h30, "ref enables");
    wrr(ADDR_PORT2, 32'h1000);
    rdc(ADDR_PORT2, 32'h10, 32'hFFFF_FFFF, "follow");
    wrr(ADDR_PORT2, 32'h0);
    wrr(ADDR_CTRL, 32'h0);
    $display("test regs done");
  endtask
  task automatic t_off;
    int k = 0;
    tick_en <= 1'b1;
    repeat (200) begin
      @(negedge clk);
      if (tx_valid !== 1'b0) k++;
    end
    chk(k, 0, "words while off");
    @(posedge clk);
    $display("test off done");
  endtask
  task automatic t_normal;
    int n = 0, k = 1;
    wrr(ADDR_RATE, 32'h11);
    wrr(ADDR_OH, 32'h1122_3344);
    wrr(ADDR_CTRL, 32'h1);
    do begin
      @(negedge clk);
      n++;
    end while (tx_sof !== 1'b1 && n < 300);
    bound(n, 300, "first frame");
    chk(tx_data, 32'h1122_3344, "frame start word");
    do begin
      @(negedge clk);
      n++;
      if (tx_valid === 1'b1 && tx_sof !== 1'b1) begin
        if (k < 4) chk({tx_oh, tx_data[31:8]}, {1'b1, 24'h112233}, "oh word");
        else chk(tx_data, 32'h0, "null payload");
        k++;
      end
    end while (tx_sof !== 1'b1 && n < 600);
    bound(n, 600, "second frame");
    chk(k, FRAME_WORDS, "frame length");
    @(posedge clk);
    $display("test normal done");
  endtask
  task automatic t_clocks;
    int k = 0;
    wrr(ADDR_RATE, 32'h0);
    wrr(ADDR_CTRL, 32'hD1);
    repeat (150) @(posedge clk);
    repeat (200) begin
      @(negedge clk);
      if (ref1 !== 1'b0 || ref2 !== 1'b0) k++;
    end
    chk(k, 0, "ref at lowest rate");
    gap(1'b1, 8, "sync div8");
    wrr(ADDR_RATE, 32'h1);
    gap(1'b0, 64, "ref div64");
    wrr(ADDR_CTRL, 32'h111);
    repeat (150) @(posedge clk);
    gap(1'b0, 16, "ref div16");
    gap(1'b1, 16, "sync div16");
    wrr(ADDR_CTRL, 32'h0);
    repeat (150) @(posedge clk);
    tick_en <= 1'b0;
    rdc(ADDR_STATUS, 32'h0, 32'hC0, "mode off");
    $display("test clocks done");
  endtask
  task automatic stream(input bit ohr);
    int k = 0;
    repeat (200) begin
      @(negedge clk);
      if (tx_valid === 1'b1) begin
        k++;
        if (ohr && poh) chk(tx_data, psof ? 32'h1122_3344 : {24'h112233, tx_data[7:0]}, "oh replaced");
        else chk(tx_data, pex, "passed word");
      end
    end
    chk(k > 150, 1'b1, "stream words");
    @(posedge clk);
  endtask
  task automatic t_through;
    wrr(ADDR_CTRL, 32'h2);
    rdc(ADDR_STATUS, 32'h380, 32'h3C0, "forced source");
    send <= 1'b1;
    stream(1'b0);
    wrr(ADDR_CTRL, 32'h3);
    repeat (150) @(posedge clk);
    rdc(ADDR_STATUS, 32'h3C0, 32'h3C0, "oh replace active");
    stream(1'b1);
    wrr(ADDR_CTRL, 32'h0);
    repeat (150) @(posedge clk);
    send <= 1'b0;
    $display("test through done");
  endtask
  initial begin
    repeat (6) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    t_reset();
    t_regs();
    t_off();
    t_normal();
    t_clocks();
    t_through();
    test_done();
  end
endmodule // otn_transmit_mode_and_clock_select_bench
